// *** rtl/usr_core.v ***
// Transmit stop-bit timing, receiver sampler and descriptor status writer.
// Assumes rx_i is asynchronous and a descriptor engine drains the status FIFO.
`timescale 1ns/1ns
`default_nettype none
`include "usr_map.vh"

// ==========================================
// Status FIFO
module usr_fifo #(
  parameter W = 26,
  parameter D = 32,
  parameter AW = 5
) (
  input wire clk_i,
  input wire rst_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [W-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [W-1:0] out_data_o
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0] cnt_q;
  wire wr = in_valid_i && in_ready_o;
  wire rd = out_valid_o && out_ready_i;
  localparam [AW:0] FULL = D;
  assign in_ready_o = (cnt_q != FULL);
  assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
  assign out_data_o = mem[rp_q];
  always @(posedge clk_i)
  begin
    if (wr)
      mem[wp_q] <= in_data_i;
  end
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (wr)
        wp_q <= wp_q + 1'b1;
      if (rd)
        rp_q <= rp_q + 1'b1;
      if (wr && !rd)
        cnt_q <= cnt_q + 1'b1;
      else if (rd && !wr)
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule // usr_fifo

// Overview of operation
// - 16x: codes 1111..1000 give 16/16..9/16 stop; 0xxx invalid; reset all ones
// - 32x: every code valid, 1111 is 32/32 down to 0000 at 17/32
// - 8x: codes 1111..1100 give 8/8..5/8; lower codes invalid; reset all ones
// - Receiver accepts next start bit once the three middle stop samples are taken
// - Continuous mode keeps empty flag set on close, unless a reception error occurred
// - Close buffer and flag idle closure after programmed count of idle bit times
// - Multidrop address: match flag 0 for second address, 1 for first
// - Break while receiving into a buffer sets its break flag
// - Character without stop bit is last byte, framing flag, new buffer
// - Bad parity character is last byte, parity flag, new buffer
// - Receiver overrun during reception sets overrun flag
// - Carrier detect negated during reception sets carrier lost flag
// - Received octet count written into length exactly once at close
module usr_core (
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_i,
  // Configuration
  input wire [1:0] os_sel_i,
  input wire [3:0] last_stop_fraction_i,
  input wire fsb_load_i,
  input wire continuous_rx_i,
  input wire parity_en_i,
  input wire parity_odd_i,
  input wire multidrop_i,
  input wire [7:0] match_addr_first_i,
  input wire [7:0] match_addr_second_i,
  input wire [7:0] idle_count_limit_i,
  input wire [15:0] max_len_i,
  input wire baud_tick_i,
  // Transmit
  input wire tx_start_i,
  output reg tx_stop_o,
  output reg fsb_invalid_o,
  // Line
  input wire rx_i,
  input wire carrier_n_i,
  // Descriptor status out
  output reg desc_valid_o,
  input wire desc_ready_i,
  output reg [9:0] desc_status_o,
  output reg [15:0] desc_length_o,
  // Received data
  output reg [7:0] rx_data_o,
  output reg rx_data_valid_o,
  input wire rx_data_taken_i
);
  localparam S_IDLE = 2'h0;
  localparam S_DATA = 2'h1;
  localparam S_STOP = 2'h2;

  function [5:0] fsb_len;
    input [1:0] os;
    input [3:0] c;
    begin
      if (os == `USR_OS32)
        fsb_len = {2'h0, c} + 6'd17;
      else if (os == `USR_OS16)
        fsb_len = {3'h0, c[2:0]} + 6'd9;
      else
        fsb_len = {4'h0, c[1:0]} + 6'd5;
    end
  endfunction

  function fsb_bad;
    input [1:0] os;
    input [3:0] c;
    begin
      if (os == `USR_OS16)
        fsb_bad = !c[3];
      else if (os == `USR_OS8)
        fsb_bad = (c[3:2] != 2'h3);
      else
        fsb_bad = 1'b0;
    end
  endfunction

  // ==========================================
  // Synchronisers
  // Third rx stage only marks the falling edge, so a line held low after a break is no start
  reg rx_m_q, rx_s_q, rx_d_q, cd_m_q, cd_s_q;
  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rx_m_q <= 1'b1;
      rx_s_q <= 1'b1;
      rx_d_q <= 1'b1;
      cd_m_q <= 1'b1;
      cd_s_q <= 1'b1;
    end
    else
    begin
      rx_m_q <= rx_i;
      rx_s_q <= rx_m_q;
      rx_d_q <= rx_s_q;
      cd_m_q <= carrier_n_i;
      cd_s_q <= cd_m_q;
    end
  end

  wire [5:0] os_n = (os_sel_i == `USR_OS32) ? 6'd32 : (os_sel_i == `USR_OS16) ? 6'd16 : 6'd8;
  wire [5:0] os_mid = {1'b0, os_n[5:1]};

  // ==========================================
  // Transmit last stop bit length
  reg [3:0] fsb_q;
  reg [5:0] tx_cnt_q;
  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      fsb_q <= `USR_FSB_RESET;
      tx_cnt_q <= 6'h00;
      tx_stop_o <= 1'b0;
      fsb_invalid_o <= 1'b0;
    end
    else
    begin
      if (fsb_load_i)
        fsb_q <= last_stop_fraction_i;
      fsb_invalid_o <= fsb_bad(os_sel_i, fsb_q);
      if (tx_start_i && !tx_stop_o)
      begin
        tx_stop_o <= 1'b1;
        tx_cnt_q <= fsb_len(os_sel_i, fsb_q);
      end
      else if (tx_stop_o && baud_tick_i)
      begin
        if (tx_cnt_q <= 6'h01)
          tx_stop_o <= 1'b0;
        tx_cnt_q <= tx_cnt_q - 6'h01;
      end
    end
  end

  // ==========================================
  // Receiver and descriptor
  wire fifo_ready;
  reg [1:0] st_q;
  reg [5:0] smp_q;
  reg [3:0] bit_q;
  reg [8:0] sh_q;
  reg [2:0] votes_q;
  reg [7:0] idle_q;
  reg [15:0] len_q;
  reg br_q, ov_q, cd_q, am_q, busy_q, md_on_q;
  reg push_q;
  reg [9:0] push_st_q;
  reg [15:0] push_len_q;
  wire [3:0] nbits = parity_en_i ? 4'd9 : 4'd8;
  wire maj = (votes_q[0] & votes_q[1]) | (votes_q[1] & votes_q[2]) | (votes_q[0] & votes_q[2]);
  // In multidrop the ninth bit flags an address, so no parity is checked
  wire par_bad = parity_en_i && !multidrop_i && ((^sh_q) != parity_odd_i);
  wire ov_now = rx_data_valid_o && !rx_data_taken_i && busy_q;
  wire cd_now = busy_q && cd_s_q;
  wire is_addr = multidrop_i && parity_en_i && sh_q[8];
  wire [7:0] ch = parity_en_i ? sh_q[7:0] : sh_q[8:1];

  task close_desc;
    input fr;
    input pr;
    input idl;
    input ov;
    input [15:0] l;
    reg err;
    begin
      // Events in the closing cycle still belong to this buffer
      err = fr | pr | ov | ov_q | br_q | cd_q | cd_now;
      push_q <= 1'b1;
      push_len_q <= l;
      push_st_q <= 10'h000;
      push_st_q[`USR_FR_BIT] <= fr;
      push_st_q[`USR_PR_BIT] <= pr;
      push_st_q[`USR_ID_BIT] <= idl;
      push_st_q[`USR_BR_BIT] <= br_q;
      push_st_q[`USR_OV_BIT] <= ov_q | ov;
      push_st_q[`USR_CD_BIT] <= cd_q | cd_now;
      push_st_q[`USR_AM_BIT] <= am_q;
      push_st_q[`USR_CM_BIT] <= continuous_rx_i;
      push_st_q[`USR_EMPTY_BIT] <= continuous_rx_i && !err;
      busy_q <= 1'b0;
      len_q <= 16'h0000;
      br_q <= 1'b0;
      ov_q <= 1'b0;
      cd_q <= 1'b0;
    end
  endtask

  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_q <= S_IDLE;
      smp_q <= 6'h00;
      bit_q <= 4'h0;
      sh_q <= 9'h000;
      votes_q <= 3'h7;
      idle_q <= 8'h00;
      len_q <= 16'h0000;
      br_q <= 1'b0;
      ov_q <= 1'b0;
      cd_q <= 1'b0;
      am_q <= 1'b0;
      md_on_q <= 1'b0;
      busy_q <= 1'b0;
      push_q <= 1'b0;
      push_st_q <= 10'h000;
      push_len_q <= 16'h0000;
      rx_data_o <= 8'h00;
      rx_data_valid_o <= 1'b0;
    end
    else
    begin
      if (push_q && fifo_ready)
        push_q <= 1'b0;
      if (rx_data_taken_i)
        rx_data_valid_o <= 1'b0;
      if (busy_q && cd_s_q)
        cd_q <= 1'b1;
      if (baud_tick_i)
      begin
        case (st_q)
          S_IDLE:
          begin
            if (!rx_s_q && rx_d_q)
            begin
              st_q <= S_DATA;
              smp_q <= 6'h01;
              bit_q <= 4'h0;
            end
            else if (smp_q == os_n - 6'h01)
            begin
              smp_q <= 6'h00;
              if (busy_q && idle_count_limit_i != 8'h00)
              begin
                if (idle_q + 8'h01 >= idle_count_limit_i && !push_q)
                begin
                  close_desc(1'b0, 1'b0, 1'b1, 1'b0, len_q);
                  idle_q <= 8'h00;
                end
                else
                  idle_q <= idle_q + 8'h01;
              end
            end
            else
              smp_q <= smp_q + 6'h01;
          end
          S_DATA:
          begin
            idle_q <= 8'h00;
            if (smp_q == os_mid - 6'h01)
              votes_q[0] <= rx_s_q;
            if (smp_q == os_mid)
              votes_q[1] <= rx_s_q;
            if (smp_q == os_mid + 6'h01)
              votes_q[2] <= rx_s_q;
            if (smp_q == os_n - 6'h01)
            begin
              smp_q <= 6'h00;
              if (bit_q != 4'h0)
                sh_q <= {maj, sh_q[8:1]};
              if (bit_q == nbits)
                st_q <= S_STOP;
              bit_q <= bit_q + 4'h1;
            end
            else
              smp_q <= smp_q + 6'h01;
          end
          default:
          begin
            if (smp_q == os_mid - 6'h01)
              votes_q[0] <= rx_s_q;
            if (smp_q == os_mid)
              votes_q[1] <= rx_s_q;
            if (smp_q == os_mid + 6'h01)
              votes_q[2] <= rx_s_q;
            smp_q <= smp_q + 6'h01;
            // Decide right after the three middle samples so a short stop still works
            if (smp_q == os_mid + 6'h02)
            begin
              st_q <= S_IDLE;
              smp_q <= 6'h00;
              if (!maj && {parity_en_i & sh_q[8], ch} == 9'h000)
              begin
                if (busy_q)
                  br_q <= 1'b1;
              end
              else if (is_addr)
              begin
                am_q <= (ch == match_addr_first_i);
                // A non-matching address shuts reception off until the next match
                md_on_q <= (ch == match_addr_first_i) || (ch == match_addr_second_i);
              end
              else if (!multidrop_i || md_on_q)
              begin
                if (rx_data_valid_o && !rx_data_taken_i)
                begin
                  if (ov_now)
                    ov_q <= 1'b1;
                end
                else
                begin
                  rx_data_o <= ch;
                  rx_data_valid_o <= 1'b1;
                end
                busy_q <= 1'b1;
                if (!maj || par_bad || len_q + 16'h0001 >= max_len_i)
                begin
                  if (!push_q)
                    close_desc(!maj, par_bad, 1'b0, ov_now, len_q + 16'h0001);
                end
                else
                  len_q <= len_q + 16'h0001;
              end
            end
          end
        endcase
      end
    end
  end

  // ==========================================
  // Output register stage after the FIFO
  wire out_v;
  wire [25:0] out_d;
  wire out_take = out_v && (!desc_valid_o || desc_ready_i);
  usr_fifo #(.W(26), .D(`USR_FIFO_DEPTH), .AW(5)) u_fifo (
    .clk_i(ref_clk_i),
    .rst_i(rst_i),
    .in_valid_i(push_q),
    .in_ready_o(fifo_ready),
    .in_data_i({push_st_q, push_len_q}),
    .out_valid_o(out_v),
    .out_ready_i(out_take),
    .out_data_o(out_d)
  );
  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      desc_valid_o <= 1'b0;
      desc_status_o <= 10'h000;
      desc_length_o <= 16'h0000;
    end
    else if (out_take)
    begin
      desc_valid_o <= 1'b1;
      desc_status_o <= out_d[25:16];
      desc_length_o <= out_d[15:0];
    end
    else if (desc_ready_i)
      desc_valid_o <= 1'b0;
  end
endmodule // usr_core
`default_nettype wire

// *** rtl/usr_map.vh ***
// Constants for the stop-bit and receive status block.
// Assumes inclusion by rtl/usr_core.v only.
`ifndef USR_MAP_VH
`define USR_MAP_VH
`define USR_FSB_RESET 4'hf
`define USR_OS8 2'h0
`define USR_OS16 2'h1
`define USR_OS32 2'h2
`define USR_CLK_HZ 20000000
`define USR_ST_BIT 0
`define USR_AM_BIT 1
`define USR_BR_BIT 2
`define USR_FR_BIT 3
`define USR_PR_BIT 4
`define USR_OV_BIT 5
`define USR_CD_BIT 6
`define USR_ID_BIT 7
`define USR_CM_BIT 8
`define USR_EMPTY_BIT 9
`define USR_FIFO_DEPTH 32
`endif

// *** verif/usr_core_properties.sv ***
// Checker for usr_core: stop-bit length, code validity and descriptor status.
// Assumes one clock domain and binding to usr_core.
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Checker
module usr_core_properties (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [1:0] os_sel_i,
  input wire logic [3:0] last_stop_fraction_i,
  input wire logic fsb_load_i,
  input wire logic baud_tick_i,
  input wire logic tx_stop_o,
  input wire logic fsb_invalid_o,
  input wire logic desc_valid_o,
  input wire logic desc_ready_i,
  input wire logic [9:0] desc_status_o,
  input wire logic [15:0] desc_length_o
);
  logic [3:0] code_q;
  logic [5:0] cnt_q;
  logic bad;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  assign bad = (os_sel_i == 2'h1 && !code_q[3]) || (os_sel_i == 2'h0 && code_q[3:2] != 2'h3);
  // Ticks counted while the stop bit stands, judged when it drops
  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      code_q <= 4'hf;
      cnt_q <= 6'h00;
    end
    else
    begin
      if (fsb_load_i)
        code_q <= last_stop_fraction_i;
      if (!tx_stop_o)
        cnt_q <= 6'h00;
      else if (baud_tick_i)
        cnt_q <= cnt_q + 6'h01;
    end
  end
  a_stop_len_x16: assert property ($fell(tx_stop_o) && os_sel_i == 2'h1 |-> cnt_q == {3'h0, code_q[2:0]} + 6'h09)
    else $error("stop length wrong at 16x");
  a_stop_len_x32: assert property ($fell(tx_stop_o) && os_sel_i == 2'h2 |-> cnt_q == {2'h0, code_q} + 6'h11)
    else $error("stop length wrong at 32x");
  a_stop_len_x8: assert property ($fell(tx_stop_o) && os_sel_i == 2'h0 |-> cnt_q == {4'h0, code_q[1:0]} + 6'h05)
    else $error("stop length wrong at 8x");
  a_invalid_code_flag: assert property (bad [*2] |-> fsb_invalid_o)
    else $error("invalid stop code not flagged");
  a_cm_keeps_empty: assert property (desc_valid_o && desc_status_o[8] && desc_status_o[6:2] == 5'h00 |-> desc_status_o[9])
    else $error("continuous close lost empty flag");
  a_error_clears_empty: assert property (desc_valid_o && desc_status_o[6:2] != 5'h00 |-> !desc_status_o[9])
    else $error("error close kept empty flag");
  a_plain_close_clear: assert property (desc_valid_o && !desc_status_o[8] |-> !desc_status_o[9])
    else $error("normal close kept empty flag");
  a_desc_held: assert property (desc_valid_o && !desc_ready_i |=> desc_valid_o && $stable(desc_length_o) && $stable(desc_status_o))
    else $error("descriptor changed before accepted");
endmodule // usr_core_properties

bind usr_core usr_core_properties u_props (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .os_sel_i(os_sel_i),
  .last_stop_fraction_i(last_stop_fraction_i), .fsb_load_i(fsb_load_i), .baud_tick_i(baud_tick_i),
  .tx_stop_o(tx_stop_o), .fsb_invalid_o(fsb_invalid_o), .desc_valid_o(desc_valid_o),
  .desc_ready_i(desc_ready_i), .desc_status_o(desc_status_o), .desc_length_o(desc_length_o));
`default_nettype wire

// *** verif/usr_line_station.sv ***
// Remote serial station driving the receive line, idle high.
// Assumes one oversample tick per clock cycle.
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Line station
module usr_line_station (
  input wire logic clk_i,
  input wire logic [1:0] os_sel_i,
  output logic rx_o,
  output logic carrier_n_o
);
  initial
  begin
    rx_o = 1'b1;
    carrier_n_o = 1'b0;
  end
  task automatic send(input logic [7:0] d, input logic par_on, input logic par, input logic stop,
    input logic short_stop);
    logic [9:0] fr;
    int os;
    begin
      os = 8 << os_sel_i;
      fr = {par, d, 1'b0};
      for (int i = 0; i < (par_on ? 10 : 9); i++)
      begin
        @(negedge clk_i);
        rx_o = fr[i];
        repeat (os - 1) @(negedge clk_i);
      end
      @(negedge clk_i);
      rx_o = stop;
      // Short stop ends just past the three middle samples plus the sampler delay
      repeat ((short_stop ? os / 2 + 4 : os) - 1) @(negedge clk_i);
      @(negedge clk_i);
      rx_o = 1'b1;
      if (!short_stop)
        repeat (2 * os) @(negedge clk_i);
    end
  endtask
  task automatic carrier(input logic negated);
    begin
      carrier_n_o = negated;
    end
  endtask
endmodule // usr_line_station
`default_nettype wire

// *** verif/usr_core_tb_top.sv ***
// Self-checking bench for usr_core: stop lengths and descriptor status.
// Assumes usr_line_station on the line and a tick every clock.
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Bench
module usr_core_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] os = 2'h1;
  logic [3:0] code = 4'hf;
  logic ld = 1'b0;
  logic cm = 1'b0;
  logic pen = 1'b0;
  logic podd = 1'b0;
  logic [15:0] max_len = 16'h0100;
  logic tx_start = 1'b0;
  logic rdy = 1'b0;
  logic taken = 1'b0;
  logic md = 1'b0;
  logic hold = 1'b0;
  logic [7:0] idle_lim = 8'h00;
  logic [7:0] rxd;
  logic rx, carrier_n, tx_stop, fsb_inv, dval, rxv;
  logic [9:0] st;
  logic [15:0] len;
  int num_errors = 0;
  int comparisons = 0;
  usr_core dut (.ref_clk_i(clk), .rst_i(rst), .os_sel_i(os), .last_stop_fraction_i(code), .fsb_load_i(ld),
    .continuous_rx_i(cm), .parity_en_i(pen), .parity_odd_i(podd), .multidrop_i(md),
    .match_addr_first_i(8'h5a), .match_addr_second_i(8'ha5), .idle_count_limit_i(idle_lim),
    .max_len_i(max_len), .baud_tick_i(1'b1), .tx_start_i(tx_start), .tx_stop_o(tx_stop),
    .fsb_invalid_o(fsb_inv), .rx_i(rx), .carrier_n_i(carrier_n), .desc_valid_o(dval), .desc_ready_i(rdy),
    .desc_status_o(st), .desc_length_o(len), .rx_data_o(rxd), .rx_data_valid_o(rxv), .rx_data_taken_i(taken));
  usr_line_station line (.clk_i(clk), .os_sel_i(os), .rx_o(rx), .carrier_n_o(carrier_n));
  initial
  begin
    forever #25 clk = ~clk;
  end
  always @(negedge clk)
    taken <= rxv && !hold;
  task automatic conclude;
    begin
      $display("comparisons %0d num_errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    begin
      comparisons++;
      if (got !== exp)
      begin
        num_errors++;
        $display("ERROR %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task automatic stop_len(input logic [1:0] o, input logic [3:0] c, input int n, input logic inv, input logic load);
    int k;
    begin
      @(negedge clk);
      os = o;
      code = c;
      ld = load;
      @(negedge clk);
      ld = 1'b0;
      repeat (3) @(negedge clk);
      check("fsb_invalid", {15'h0000, inv}, {15'h0000, fsb_inv});
      if (!inv)
      begin
        tx_start = 1'b1;
        @(negedge clk);
        tx_start = 1'b0;
        k = 0;
        while (tx_stop !== 1'b1 && k < 8)
        begin
          @(negedge clk);
          k++;
        end
        if (k == 8)
        begin
          num_errors++;
          $display("ERROR tx_stop expected 1 seen %b", tx_stop);
          conclude;
        end
        k = 0;
        while (tx_stop === 1'b1 && k < 40)
        begin
          @(negedge clk);
          k++;
        end
        check("stop_ticks", n[15:0], k[15:0]);
      end
    end
  endtask
  task automatic get_desc(input logic [15:0] exp_len, input logic [9:0] mask, input logic [9:0] exp);
    int w;
    begin
      w = 0;
      while (dval !== 1'b1 && w < 5000)
      begin
        @(negedge clk);
        w++;
      end
      if (w == 5000)
      begin
        num_errors++;
        $display("ERROR desc_valid expected 1 seen %b", dval);
        conclude;
      end
      check("desc_length", exp_len, len);
      check("desc_status", {6'h00, exp & mask}, {6'h00, st & mask});
      rdy = 1'b1;
      @(negedge clk);
      rdy = 1'b0;
    end
  endtask
  task automatic t_stop;
    begin
      check("desc_valid", 16'h0000, {15'h0000, dval});
      stop_len(2'h1, 4'hf, 16, 1'b0, 1'b0);
      stop_len(2'h1, 4'h8, 9, 1'b0, 1'b1);
      stop_len(2'h1, 4'h7, 0, 1'b1, 1'b1);
      stop_len(2'h2, 4'h0, 17, 1'b0, 1'b1);
      stop_len(2'h2, 4'hf, 32, 1'b0, 1'b1);
      stop_len(2'h0, 4'hc, 5, 1'b0, 1'b1);
      stop_len(2'h0, 4'hb, 0, 1'b1, 1'b1);
      stop_len(2'h1, 4'hf, 16, 1'b0, 1'b1);
    end
  endtask
  task automatic t_rx;
    begin
      cm = 1'b1;
      line.send(8'h55, 1'b0, 1'b0, 1'b1, 1'b1);
      line.send(8'ha3, 1'b0, 1'b0, 1'b1, 1'b1);
      line.send(8'h3c, 1'b0, 1'b0, 1'b0, 1'b0);
      get_desc(16'h0003, 10'h308, 10'h108);
      cm = 1'b0;
      pen = 1'b1;
      podd = 1'b1;
      line.send(8'h07, 1'b1, 1'b0, 1'b1, 1'b0);
      line.send(8'h01, 1'b1, 1'b1, 1'b1, 1'b0);
      get_desc(16'h0002, 10'h318, 10'h010);
      pen = 1'b0;
      max_len = 16'h0002;
      cm = 1'b1;
      line.send(8'h11, 1'b0, 1'b0, 1'b1, 1'b0);
      line.send(8'h22, 1'b0, 1'b0, 1'b1, 1'b0);
      get_desc(16'h0002, 10'h37c, 10'h300);
      cm = 1'b0;
      line.send(8'h33, 1'b0, 1'b0, 1'b1, 1'b0);
      line.send(8'h44, 1'b0, 1'b0, 1'b1, 1'b0);
      get_desc(16'h0002, 10'h300, 10'h000);
      max_len = 16'h0100;
    end
  endtask
  task automatic t_err;
    begin
      max_len = 16'h0002;
      cm = 1'b1;
      hold = 1'b1;
      line.send(8'h71, 1'b0, 1'b0, 1'b1, 1'b0);
      line.send(8'h72, 1'b0, 1'b0, 1'b1, 1'b0);
      check("rx_data", 16'h0071, {8'h00, rxd});
      check("rx_data_valid", 16'h0001, {15'h0000, rxv});
      get_desc(16'h0002, 10'h320, 10'h120);
      hold = 1'b0;
      cm = 1'b0;
      line.send(8'h61, 1'b0, 1'b0, 1'b1, 1'b0);
      line.carrier(1'b1);
      repeat (4) @(negedge clk);
      line.carrier(1'b0);
      line.send(8'h62, 1'b0, 1'b0, 1'b1, 1'b0);
      get_desc(16'h0002, 10'h340, 10'h040);
      max_len = 16'h0100;
      idle_lim = 8'h04;
      line.send(8'h42, 1'b0, 1'b0, 1'b1, 1'b0);
      line.send(8'h00, 1'b0, 1'b0, 1'b0, 1'b0);
      get_desc(16'h0001, 10'h384, 10'h084);
      idle_lim = 8'h00;
    end
  endtask
  task automatic t_multi;
    begin
      md = 1'b1;
      pen = 1'b1;
      max_len = 16'h0002;
      line.send(8'h5a, 1'b1, 1'b1, 1'b1, 1'b0);
      line.send(8'h12, 1'b1, 1'b0, 1'b1, 1'b0);
      line.send(8'h34, 1'b1, 1'b0, 1'b1, 1'b0);
      get_desc(16'h0002, 10'h31a, 10'h002);
      line.send(8'ha5, 1'b1, 1'b1, 1'b1, 1'b0);
      line.send(8'h56, 1'b1, 1'b0, 1'b1, 1'b0);
      line.send(8'h78, 1'b1, 1'b0, 1'b1, 1'b0);
      get_desc(16'h0002, 10'h31a, 10'h000);
      md = 1'b0;
      pen = 1'b0;
    end
  endtask
  initial
  begin
    repeat (100000) @(negedge clk);
    num_errors++;
    conclude;
  end
  initial
  begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    t_stop;
    t_rx;
    t_err;
    t_multi;
    conclude;
  end
endmodule // usr_core_tb_top
`default_nettype wire
